// ### src/rtcu_core.sv
// Summary of operation
// - A one-second period ends in an update cycle that advances time and may raise alarm.
// - With freeze set, the host copy stays still while the internal copy keeps counting.
// - Pending flag rises a fixed interval before update; update end clears it, sets done.
// - Time, alarm and calendar bytes are BCD or binary, chosen by one format bit.
// - Twelve-hour mode puts PM in hour bit 7, hours 1 to 12.
// - Twenty-four-hour mode hours run 0 to 23 in the chosen format.
// - Weekday counts 1 to 7, Sunday being 1.
// - Century bit is read-only at extended 7Fh bit 7, refreshed by year writes.
// - The next update rewrites, in the selected format, seconds and only the other bytes that advance.
// - Reference clock output always runs, whatever the oscillator and rate fields hold.
// - Each event sets its flag; a request follows only with its enable set.
// - Summary flag is set with every interrupt request.
// - Reading the flag register clears all flags and releases the request pin.
// - Rate select picks the periodic event period; zero gives no events.
// - Update compares day, hours, minutes, seconds with alarms; full match sets alarm flag.
// - Alarm byte with top two bits set, or day field zero, is ignored.
// - Done flag every update; request only with its enable and freeze clear.
// - Pending flag is read-only and held clear while freeze is set.
// - Update interrupt enable is cleared while freeze is set.
// - Oscillator codes 01x run divider, 11x hold it; first update 500 ms after start.
// - Hour format bit 1 selects 24-hour, 0 selects 12-hour, for time and alarm.
`timescale 1ns/1ps
`include "rtcu_consts.svh"

module rtcu_core #(
  parameter int SEC_TICKS = `RTCU_OSC_HZ
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] adIn,
  output logic [7:0] adOut,
  output logic adOe,
  input wire logic asIn,
  input wire logic dsIn,
  input wire logic rwIn,
  input wire logic csN,
  input wire logic extramIn,
  input wire logic oscIn,
  output logic refClkOut,
  output logic intOut,
  output logic intOe
);

  localparam int DIV_W = $clog2(SEC_TICKS);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SEC_TICKS - 1);
  localparam logic [DIV_W-1:0] DIV_START =
    DIV_W'(SEC_TICKS - (SEC_TICKS * `RTCU_FIRST_UPDATE_MS) / 1000);
  localparam logic [DIV_W-1:0] DIV_PEND = DIV_W'(SEC_TICKS - 1 - `RTCU_PRE_UPDATE_TICKS);

  rtcu_pkg::rtcu_pins_t pinS1_ff, pinS2_ff, pinS3_ff, pin_ff, pinPrev_ff;
  rtcu_pkg::rtcu_flags_t flags_ff, nxt_flags;
  logic [7:0] liveRegs_ff [0:9];
  logic [7:0] userRegs_ff [0:9];
  logic [7:0] nxtLive [0:9];
  logic [7:0] stdAddr_ff, extAddr_ff, adOut_ff, rdData;
  logic [DIV_W-1:0] div_ff;
  logic [3:0] rate_ff;
  logic [2:0] osc_ff;
  logic [5:0] dayAlarm_ff;
  logic uti_ff, pie_ff, aie_ff, uie_ff, df_ff, hf_ff, dse_ff;
  logic uip_ff, irq_summary_flag_ff, intOe_ff, adOe_ff, refClk_ff, century_ff;
  logic oscTick, running, updateTick, periodTick, alarmHit, irqNow;
  logic asFall, dsFall, hostWr, clrFlags, regWrB;
  logic [7:0] wrData;
  logic [DIV_W-1:0] rateMask;
  logic [7:0] sec, mnt, h24, h12, newH24, newH12, dim, mon, yr, mday, dow;
  logic [7:0] h12Fmt;
  logic cMin, cHour, cDay, cMon;

  // Converts a stored byte to its binary value.
  function automatic logic [7:0] fromFmt(input logic [7:0] v, input logic bin);
    logic [7:0] tens;
    tens = {4'h0, v[7:4]};
    fromFmt = bin ? v : 8'((tens << 3) + (tens << 1) + {4'h0, v[3:0]});
  endfunction

  // Converts a binary value to the selected stored format.
  function automatic logic [7:0] toFmt(input logic [7:0] v, input logic bin);
    logic [7:0] t;
    logic [7:0] u;
    t = v / 8'h0a;
    u = v % 8'h0a;
    toFmt = bin ? v : {t[3:0], u[3:0]};
  endfunction

  // Number of days in a month; every fourth year is a leap year.
  function automatic logic [7:0] daysIn(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02: daysIn = (y[1:0] == 2'b00) ? 8'h1d : 8'h1c;
      8'h04, 8'h06, 8'h09, 8'h0b: daysIn = 8'h1e;
      default: daysIn = 8'h1f;
    endcase
  endfunction

  // An alarm byte with both top bits set is excluded from matching.
  function automatic logic dontCare(input logic [7:0] a);
    dontCare = (a[7:6] == 2'b11);
  endfunction

  // Period of the periodic event as a power of two of oscillator ticks.
  function automatic logic [DIV_W-1:0] maskFor(input logic [3:0] rs);
    logic [4:0] lg;
    case (rs)
      4'h1: lg = 5'(`RTCU_RATE1_LOG);
      4'h2: lg = 5'(`RTCU_RATE2_LOG);
      default: lg = 5'(rs - 4'h1);
    endcase
    maskFor = DIV_W'((32'h0000_0001 << lg) - 32'h0000_0001);
  endfunction

  // Three-stage sampling of all pins; a bit changes once stages two and three agree.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pinS1_ff <= '0;
      pinS2_ff <= '0;
      pinS3_ff <= '0;
      pin_ff <= '0;
      pinPrev_ff <= '0;
    end
    else
    begin
      pinS1_ff <= {adIn, asIn, dsIn, rwIn, csN, extramIn, oscIn};
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      pin_ff <= (pinS2_ff & pinS3_ff) | (pin_ff & (pinS2_ff ^ pinS3_ff));
      pinPrev_ff <= pin_ff;
    end
  end

  // Edges of the strobes and the access decode.
  assign asFall = pinPrev_ff.as & ~pin_ff.as;
  assign dsFall = pinPrev_ff.ds & ~pin_ff.ds;
  assign wrData = pin_ff.ad;
  assign hostWr = dsFall & ~pin_ff.rw & ~pin_ff.csN & ~pin_ff.extram;
  assign regWrB = hostWr && (stdAddr_ff == `RTCU_ADDR_CTLB);
  assign clrFlags = dsFall & pin_ff.rw & ~pin_ff.csN & ~pin_ff.extram &
                    (stdAddr_ff == `RTCU_ADDR_FLAGS);

  // Address latches, one per bank, loaded on the falling address strobe.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      stdAddr_ff <= 8'h00;
      extAddr_ff <= 8'h00;
    end
    else if (asFall)
    begin
      if (pin_ff.extram)
        extAddr_ff <= pin_ff.ad;
      else
        stdAddr_ff <= pin_ff.ad;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      refClk_ff <= 1'b0;
    else
      refClk_ff <= pin_ff.osc;
  end

  assign running = (osc_ff[2:1] == 2'b01);
  assign oscTick = pin_ff.osc & ~pinPrev_ff.osc;
  assign updateTick = oscTick & running & (div_ff == DIV_LAST);
  assign rateMask = maskFor(rate_ff);
  assign periodTick = oscTick & running & (rate_ff != 4'h0) &
                      (((div_ff + DIV_W'(1)) & rateMask) == '0);

  always_ff @(posedge clk)
  begin
    if (!resetn)
      div_ff <= DIV_START;
    else if (!running)
      div_ff <= DIV_START;
    else if (oscTick)
      div_ff <= div_ff + DIV_W'(1);
  end

  always_comb
  begin
    for (int i = 0; i < `RTCU_NUM_TIME; i++)
      nxtLive[i] = liveRegs_ff[i];
    sec = fromFmt(liveRegs_ff[0], df_ff);
    mnt = fromFmt(liveRegs_ff[2], df_ff);
    dow = liveRegs_ff[6];
    mday = fromFmt(liveRegs_ff[7], df_ff);
    mon = fromFmt(liveRegs_ff[8], df_ff);
    yr = fromFmt(liveRegs_ff[9], df_ff);
    h12 = fromFmt({1'b0, liveRegs_ff[4][6:0]}, df_ff);
    if (hf_ff)
      h24 = fromFmt(liveRegs_ff[4], df_ff);
    else
      h24 = 8'((h12 == 8'h0c ? 8'h00 : h12) + (liveRegs_ff[4][7] ? 8'h0c : 8'h00));
    dim = daysIn(mon, yr);
    cMin = (sec >= 8'h3b);
    cHour = cMin && (mnt >= 8'h3b);
    cDay = cHour && (h24 >= 8'h17);
    cMon = cDay && (mday >= dim);
    newH24 = cHour ? (cDay ? 8'h00 : 8'(h24 + 8'h01)) : h24;
    newH12 = (newH24 >= 8'h0c) ? 8'(newH24 - 8'h0c) : newH24;
    if (newH12 == 8'h00)
      newH12 = 8'h0c;
    // The twelve-hour value in stored format; bit 7 is replaced by the PM marker.
    h12Fmt = toFmt(newH12, df_ff);
    nxtLive[0] = toFmt(cMin ? 8'h00 : 8'(sec + 8'h01), df_ff);
    if (cMin)
      nxtLive[2] = toFmt(cHour ? 8'h00 : 8'(mnt + 8'h01), df_ff);
    if (cHour && !hf_ff)
      nxtLive[4] = {(newH24 >= 8'h0c), h12Fmt[6:0]};
    else if (cHour)
      nxtLive[4] = toFmt(newH24, df_ff);
    if (cDay)
      nxtLive[6] = (dow >= 8'h07) ? 8'h01 : 8'(dow + 8'h01);
    if (cDay)
      nxtLive[7] = toFmt(cMon ? 8'h01 : 8'(mday + 8'h01), df_ff);
    if (cMon)
      nxtLive[8] = toFmt((mon >= 8'h0c) ? 8'h01 : 8'(mon + 8'h01), df_ff);
    if (cMon && mon >= 8'h0c)
      nxtLive[9] = toFmt((yr >= 8'h63) ? 8'h00 : 8'(yr + 8'h01), df_ff);
  end

  assign alarmHit = (dontCare(liveRegs_ff[1]) || nxtLive[0] == liveRegs_ff[1]) &&
                    (dontCare(liveRegs_ff[3]) || nxtLive[2] == liveRegs_ff[3]) &&
                    (dontCare(liveRegs_ff[5]) || nxtLive[4] == liveRegs_ff[5]) &&
                    (dayAlarm_ff == 6'h00 || nxtLive[7] == {2'b00, dayAlarm_ff});

  // Internal copy: host writes win, otherwise it advances on every update.
  generate
    for (genvar g = 0; g < `RTCU_NUM_TIME; g++)
    begin : g_time
      always_ff @(posedge clk)
      begin
        if (!resetn)
          liveRegs_ff[g] <= (g >= 6) ? `RTCU_RST_DATE : `RTCU_RST_TIME;
        else if (hostWr && stdAddr_ff == 8'(g))
          liveRegs_ff[g] <= wrData;
        else if (updateTick)
          liveRegs_ff[g] <= nxtLive[g];
      end

      always_ff @(posedge clk)
      begin
        if (!resetn)
          userRegs_ff[g] <= (g >= 6) ? `RTCU_RST_DATE : `RTCU_RST_TIME;
        else if (hostWr && stdAddr_ff == 8'(g))
          userRegs_ff[g] <= wrData;
        else if (updateTick && !uti_ff)
          userRegs_ff[g] <= nxtLive[g];
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!resetn)
      century_ff <= 1'b0;
    else if (hostWr && stdAddr_ff == `RTCU_ADDR_YEAR)
      century_ff <= (fromFmt(wrData, df_ff) < `RTCU_CENTURY_BIT_PIVOT);
    else if (updateTick && nxtLive[9] == 8'h00 && liveRegs_ff[9] != 8'h00)
      century_ff <= 1'b1;
  end

  // Control register A and the alarm_month_day field.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rate_ff <= `RTCU_RST_RATE;
      osc_ff <= `RTCU_RST_OSC;
      dayAlarm_ff <= `RTCU_RST_DAYAL;
    end
    else if (hostWr && stdAddr_ff == `RTCU_ADDR_CTLA)
    begin
      rate_ff <= wrData[`RTCU_A_RATE_LSB +: 4];
      osc_ff <= wrData[`RTCU_A_OSC_LSB +: 3];
    end
    else if (hostWr && stdAddr_ff == `RTCU_ADDR_CTLD)
      dayAlarm_ff <= wrData[5:0];
  end

  // Control register B.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      {uti_ff, pie_ff, aie_ff, uie_ff, df_ff, hf_ff, dse_ff} <= 7'h00;
    end
    else if (regWrB)
    begin
      uti_ff <= wrData[`RTCU_B_FREEZE];
      pie_ff <= wrData[`RTCU_B_PIE];
      aie_ff <= wrData[`RTCU_B_AIE];
      uie_ff <= wrData[`RTCU_B_UIE] & ~wrData[`RTCU_B_FREEZE];
      df_ff <= wrData[`RTCU_B_NUMFMT];
      hf_ff <= wrData[`RTCU_B_HOURFMT];
      dse_ff <= wrData[`RTCU_B_DSE];
    end
    else if (uti_ff)
      uie_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      uip_ff <= 1'b0;
    else if (uti_ff || updateTick)
      uip_ff <= 1'b0;
    else if (oscTick && running && div_ff == DIV_PEND)
      uip_ff <= 1'b1;
  end

  always_comb
  begin
    nxt_flags.pf = periodTick | (flags_ff.pf & ~clrFlags);
    nxt_flags.af = (updateTick & alarmHit) | (flags_ff.af & ~clrFlags);
    nxt_flags.uf = updateTick | (flags_ff.uf & ~clrFlags);
    irqNow = (nxt_flags.pf & pie_ff) | (nxt_flags.af & aie_ff) |
             (nxt_flags.uf & uie_ff & ~uti_ff);
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      flags_ff <= '0;
      irq_summary_flag_ff <= 1'b0;
      intOe_ff <= 1'b0;
    end
    else
    begin
      flags_ff <= nxt_flags;
      irq_summary_flag_ff <= irqNow | (irq_summary_flag_ff & ~clrFlags);
      intOe_ff <= irqNow | (intOe_ff & ~clrFlags);
    end
  end

  // Read data selection for both banks.
  always_comb
  begin
    rdData = 8'h00;
    if (pin_ff.extram)
    begin
      if (extAddr_ff == `RTCU_ADDR_EXT_IDX)
        rdData = {century_ff, extAddr_ff[6:0]};
    end
    else if (stdAddr_ff < 8'(`RTCU_NUM_TIME))
      rdData = userRegs_ff[stdAddr_ff[3:0]];
    else
    begin
      case (stdAddr_ff)
        `RTCU_ADDR_CTLA: rdData = {uip_ff, osc_ff, rate_ff};
        `RTCU_ADDR_CTLB: rdData = {uti_ff, pie_ff, aie_ff, uie_ff, 1'b0, df_ff, hf_ff, dse_ff};
        `RTCU_ADDR_FLAGS: rdData = {irq_summary_flag_ff, flags_ff.pf, flags_ff.af, flags_ff.uf, 4'h0};
        `RTCU_ADDR_CTLD: rdData = {2'b10, dayAlarm_ff};
        default: rdData = 8'h00;
      endcase
    end
  end

  // Data bus drive during a selected read with the data strobe high.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      adOut_ff <= 8'h00;
      adOe_ff <= 1'b0;
    end
    else
    begin
      adOut_ff <= rdData;
      adOe_ff <= pin_ff.ds & pin_ff.rw & ~pin_ff.csN;
    end
  end

  assign adOut = adOut_ff;
  assign adOe = adOe_ff;
  assign refClkOut = refClk_ff;
  assign intOut = 1'b0 & irq_summary_flag_ff;
  assign intOe = intOe_ff;

  property p_pendFreeze;
    @(posedge clk) disable iff (!resetn) uti_ff |=> !uip_ff;
  endproperty
  a_pendFreeze: assert property (p_pendFreeze) else $error("pending set under freeze");

  property p_uieFreeze;
    @(posedge clk) disable iff (!resetn) uti_ff && !regWrB |=> !uie_ff;
  endproperty
  a_uieFreeze: assert property (p_uieFreeze) else $error("update enable kept");

  property p_updDone;
    @(posedge clk) disable iff (!resetn) updateTick |=> flags_ff.uf && !uip_ff;
  endproperty
  a_updDone: assert property (p_updDone) else $error("update end flags wrong");

  property p_freeze;
    @(posedge clk) disable iff (!resetn)
      uti_ff && !hostWr |=> $stable(userRegs_ff[0]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("host copy moved under freeze");

  property p_updIrq;
    @(posedge clk) disable iff (!resetn)
      flags_ff.uf && uie_ff && !uti_ff && !clrFlags |=> intOe_ff;
  endproperty
  a_updIrq: assert property (p_updIrq) else $error("update request missing");

  property p_summary;
    @(posedge clk) disable iff (!resetn) intOe_ff |-> irq_summary_flag_ff;
  endproperty
  a_summary: assert property (p_summary) else $error("summary flag missing");

  property p_clear;
    @(posedge clk) disable iff (!resetn)
      clrFlags && !updateTick && !periodTick |=> flags_ff == '0 && !intOe_ff;
  endproperty
  a_clear: assert property (p_clear) else $error("flag read did not clear");

  property p_alarm;
    @(posedge clk) disable iff (!resetn) updateTick && alarmHit |=> flags_ff.af;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag missing");

  property p_dow;
    @(posedge clk) disable iff (!resetn)
      updateTick && cDay && liveRegs_ff[6] == 8'h07 && !hostWr |=> liveRegs_ff[6] == 8'h01;
  endproperty
  a_dow: assert property (p_dow) else $error("weekday did not wrap");

  property p_ref;
    @(posedge clk) disable iff (!resetn) ##1 refClk_ff == $past(pin_ff.osc);
  endproperty
  a_ref: assert property (p_ref) else $error("reference clock stopped");

  // no periodic event at code zero
  property p_rate0;
    @(posedge clk) disable iff (!resetn) rate_ff == 4'h0 |=> !$rose(flags_ff.pf);
  endproperty
  a_rate0: assert property (p_rate0) else $error("periodic event at rate zero");

endmodule // rtcu_core

// ### src/rtcu_consts.svh
`ifndef RTCU_CONSTS_SVH
`define RTCU_CONSTS_SVH

// Standard bank offsets of the clock, alarm and calendar bytes.
`define RTCU_ADDR_SEC 8'h00
`define RTCU_ADDR_SEC_AL 8'h01
`define RTCU_ADDR_MIN 8'h02
`define RTCU_ADDR_MIN_AL 8'h03
`define RTCU_ADDR_HOUR 8'h04
`define RTCU_ADDR_HOUR_AL 8'h05
`define RTCU_ADDR_DOW 8'h06
`define RTCU_ADDR_MDAY 8'h07
`define RTCU_ADDR_MONTH 8'h08
`define RTCU_ADDR_YEAR 8'h09
`define RTCU_NUM_TIME 10
// Control and status offsets.
`define RTCU_ADDR_CTLA 8'h0a
`define RTCU_ADDR_CTLB 8'h0b
`define RTCU_ADDR_FLAGS 8'h0c
`define RTCU_ADDR_CTLD 8'h0d
// Extended bank index that carries the century bit.
`define RTCU_ADDR_EXT_IDX 8'h7f

// Control register B field positions.
`define RTCU_B_FREEZE 7
`define RTCU_B_PIE 6
`define RTCU_B_AIE 5
`define RTCU_B_UIE 4
`define RTCU_B_NUMFMT 2
`define RTCU_B_HOURFMT 1
`define RTCU_B_DSE 0
// Control register A field positions.
`define RTCU_A_PEND 7
`define RTCU_A_OSC_LSB 4
`define RTCU_A_RATE_LSB 0

// Reset values.
`define RTCU_RST_RATE 4'h0
`define RTCU_RST_OSC 3'h0
`define RTCU_RST_TIME 8'h00
`define RTCU_RST_DATE 8'h01
`define RTCU_RST_DAYAL 6'h00

// Oscillator time base and timing figures.
`define RTCU_OSC_HZ 32768
`define RTCU_PRE_UPDATE_US 244
`define RTCU_FIRST_UPDATE_MS 500
`define RTCU_PRE_UPDATE_TICKS ((`RTCU_PRE_UPDATE_US * `RTCU_OSC_HZ + 999999) / 1000000)
// Oscillator ticks per period code 1 and 2 are the same as codes 8 and 9.
`define RTCU_RATE1_LOG 7
`define RTCU_RATE2_LOG 8
// Written years below this binary value belong to the later century.
`define RTCU_CENTURY_BIT_PIVOT 8'h50

`endif

// ### src/rtcu_pkg.sv
package rtcu_pkg;

  // Pins of the multiplexed host bus and the oscillator, sampled together.
  typedef struct packed {
    logic [7:0] ad;
    logic as;
    logic ds;
    logic rw;
    logic csN;
    logic extram;
    logic osc;
  } rtcu_pins_t;

  // Event flags of the flag register.
  typedef struct packed {
    logic pf;
    logic af;
    logic uf;
  } rtcu_flags_t;

endpackage

// ### testbench/rtcu_host.sv
`timescale 1ns/1ps
// Host processor on the multiplexed bus, using wide margins on every strobe.
module rtcu_host (
  input wire logic clk,
  input wire logic [7:0] adBus,
  output rtcu_pkg::rtcu_pins_t pins,
  output logic adEn
);
  // Idle bus: strobes low, chip deselected, address/data released.
  initial
  begin
    pins = '0;
    pins.csN = 1'b1;
    pins.rw = 1'b1;
    adEn = 1'b0;
  end

  // Lets a number of clock edges pass and lands just after the last one.
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Address phase; the extended bank selects the other address latch.
  task automatic addr(input logic [7:0] a, input logic ext);
    pins.extram = ext;
    pins.ad = a;
    adEn = 1'b1;
    pins.as = 1'b1;
    hold(6);
    pins.as = 1'b0;
    hold(6);
  endtask

  // Write cycle: data is held well past the falling data strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr(a, 1'b0);
    pins.rw = 1'b0;
    pins.csN = 1'b0;
    pins.ad = d;
    pins.ds = 1'b1;
    hold(6);
    pins.ds = 1'b0;
    hold(6);
    pins.csN = 1'b1;
    pins.rw = 1'b1;
    adEn = 1'b0;
    hold(2);
  endtask

  // Read cycle: the bus is released and sampled while the data strobe is high.
  task automatic rd(input logic [7:0] a, input logic ext, output logic [7:0] d);
    addr(a, ext);
    adEn = 1'b0;
    pins.csN = 1'b0;
    pins.ds = 1'b1;
    hold(8);
    d = adBus;
    pins.ds = 1'b0;
    hold(6);
    pins.csN = 1'b1;
    pins.extram = 1'b0;
    hold(2);
  endtask
endmodule // rtcu_host

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] PROG [10] = '{8'h3a, 8'h00, 8'h3b, 8'h00, 8'h17, 8'h00, 8'h07,
    8'h1f, 8'h0c, 8'h63};
  localparam logic [7:0] WRAP [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
    8'h01, 8'h01, 8'h00};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic osc = 1'b0;
  logic [7:0] adBus;
  logic [7:0] lastAd = 8'h00;
  logic [7:0] adOut;
  logic adOe, adEn, refClkOut, intOut, intOe, intPinN;
  rtcu_pkg::rtcu_pins_t hostPins;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;

  // Bus level from its driver; a floating bus shows the inverse of its last level.
  assign adBus = adOe ? adOut : (adEn ? hostPins.ad : ~lastAd);
  assign intPinN = intOe ? intOut : 1'b1;
  always @(posedge clk) lastAd <= adBus;
  always @(posedge clk) cyc <= cyc + 1;
  // System clock and a crystal tick every sixteen system clocks.
  always #50 clk = ~clk;
  always #800 osc = ~osc;

  rtcu_core #(.SEC_TICKS(64)) rtcu_core_i (.clk(clk), .resetn(resetn), .adIn(adBus),
    .adOut(adOut), .adOe(adOe), .asIn(hostPins.as), .dsIn(hostPins.ds), .rwIn(hostPins.rw),
    .csN(hostPins.csN), .extramIn(hostPins.extram), .oscIn(osc), .refClkOut(refClkOut),
    .intOut(intOut), .intOe(intOe));
  rtcu_host rtcu_host_i (.clk(clk), .adBus(adBus), .pins(hostPins), .adEn(adEn));

  // Counts a comparison and reports it at once when it fails.
  task automatic cond(input bit ok, input string what);
    checked++;
    if (!ok)
    begin
      n_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  // Reads a standard-bank byte and compares it.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rtcu_host_i.rd(a, 1'b0, d);
    cond(d === exp, $sformatf("read %h gave %h want %h", a, d, exp));
  endtask

  // Waits, bounded, for the request pin to be pulled low.
  task automatic wait_irq(input int limit, output int n);
    n = 0;
    while (intPinN !== 1'b0 && n < limit)
    begin
      rtcu_host_i.hold(1);
      n++;
    end
    cond(n < limit, "no interrupt request");
  endtask

  task automatic t_reset;
    rchk(8'h0a, 8'h00);
    rchk(8'h0b, 8'h00);
    rchk(8'h0c, 8'h00);
    rchk(8'h06, 8'h01);
    rchk(8'h20, 8'h00);
    cond(intPinN === 1'b1, "request pin not idle");
    @(posedge osc);
    rtcu_host_i.hold(8);
    cond(refClkOut === 1'b1, "reference clock stuck low");
    @(negedge osc);
    rtcu_host_i.hold(8);
    cond(refClkOut === 1'b0, "reference clock stuck high");
  endtask

  task automatic t_program;
    logic [7:0] d;
    int n;
    rtcu_host_i.wr(8'h0b, 8'h86);
    for (int i = 0; i < 10; i++)
      rtcu_host_i.wr(8'(i), PROG[i]);
    rtcu_host_i.rd(8'h7f, 1'b1, d);
    cond(d === 8'h7f, "century after year 99");
    rtcu_host_i.wr(8'h0b, 8'h16);
    rtcu_host_i.wr(8'h0a, 8'h20);
    wait_irq(1200, n);
    cond(n > 470 && n < 530, "first update not at half second");
    rchk(8'h0c, 8'h90);
    rchk(8'h00, 8'h3b);
    wait_irq(1200, n);
    rchk(8'h0c, 8'hb0);
    cond(intPinN === 1'b1, "request held after flag read");
    for (int i = 0; i < 10; i++)
      rchk(8'(i), WRAP[i]);
    rtcu_host_i.rd(8'h7f, 1'b1, d);
    cond(d === 8'hff, "century after wrap");
  endtask

  task automatic t_freeze;
    logic [7:0] d;
    int n;
    wait_irq(1200, n);
    rchk(8'h0c, 8'h90);
    rtcu_host_i.wr(8'h0b, 8'h96);
    rchk(8'h0b, 8'h86);
    rchk(8'h00, 8'h01);
    rtcu_host_i.hold(1100);
    rchk(8'h00, 8'h01);
    rchk(8'h0a, 8'h20);
    cond(intPinN === 1'b1, "update request under freeze");
    rchk(8'h0c, 8'h10);
    rtcu_host_i.wr(8'h0b, 8'h16);
    wait_irq(1200, n);
    rchk(8'h00, 8'h03);
    rchk(8'h0c, 8'h90);
    d = 8'h00;
    n = 0;
    while (d[7] !== 1'b1 && n < 80)
    begin
      rtcu_host_i.rd(8'h0a, 1'b0, d);
      n++;
    end
    cond(d[7] === 1'b1, "pending flag never rose");
    wait_irq(300, n);
    rchk(8'h0a, 8'h20);
  endtask

  task automatic t_periodic;
    logic [7:0] d;
    int n, t0;
    rtcu_host_i.wr(8'h0b, 8'h46);
    rtcu_host_i.wr(8'h0a, 8'h26);
    rtcu_host_i.rd(8'h0c, 1'b0, d);
    wait_irq(700, n);
    t0 = cyc;
    rtcu_host_i.rd(8'h0c, 1'b0, d);
    cond(d[7:6] === 2'b11, "periodic flag or summary missing");
    cond(intPinN === 1'b1, "request held after flag read");
    wait_irq(700, n);
    cond(cyc - t0 == 512, "periodic spacing wrong");
    rtcu_host_i.wr(8'h0b, 8'h06);
    rtcu_host_i.rd(8'h0c, 1'b0, d);
    rtcu_host_i.hold(600);
    cond(intPinN === 1'b1, "request without enable");
    rtcu_host_i.rd(8'h0c, 1'b0, d);
    cond(d[7:6] === 2'b01, "masked periodic flags wrong");
    rtcu_host_i.wr(8'h0a, 8'h20);
    rtcu_host_i.rd(8'h0c, 1'b0, d);
    rtcu_host_i.hold(600);
    rtcu_host_i.rd(8'h0c, 1'b0, d);
    cond(d[6] === 1'b0, "periodic event with rate zero");
  endtask

  // Prints the verdict and ends the run.
  task automatic complete_run;
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence: reset for twenty clocks, then every scenario in turn.
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    rtcu_host_i.hold(5);
    t_reset();
    t_program();
    t_freeze();
    t_periodic();
    complete_run();
  end

  // Watchdog well beyond the expected run of some nine thousand clocks.
  initial
  begin
    #4000000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end
endmodule // tb_top
